//--- scroll_idle_pkg.sv
// constants and types shared by the scroll, idle and pixel format command block
package scroll_idle_pkg;
  // command codes as seen in the command byte
  localparam logic [7:0] CMD_SCROLL_AREA  = 8'h33;
  localparam logic [7:0] CMD_SCROLL_START = 8'h37;
  localparam logic [7:0] CMD_IDLE_EXIT    = 8'h38;
  localparam logic [7:0] CMD_IDLE_ENTRY   = 8'h39;
  localparam logic [7:0] CMD_PIXEL_FORMAT = 8'h3A;
  // apb byte addresses
  localparam logic [7:0] ADDR_CMD         = 8'h00;
  localparam logic [7:0] ADDR_PARAM       = 8'h04;
  localparam logic [7:0] ADDR_CTRL        = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0C;
  localparam logic [7:0] ADDR_SCROLL      = 8'h10;
  localparam logic [7:0] ADDR_FORMAT      = 8'h14;
  // reset values and field positions
  localparam logic [8:0] SCROLL_RESET     = 9'h000;
  localparam logic [7:0] FORMAT_RESET     = 8'h01;
  localparam int         FMT_BIT          = 0;
  localparam int         ADDR_HI_BIT      = 0;
  localparam int         CTRL_ORDER_BIT   = 0;
  localparam int         CTRL_SWRST_BIT   = 1;
  localparam int         LINE_W           = 9;
  localparam int         CHAN_W           = 6;
  // frame period counts in clock cycles
  localparam logic [15:0] NORMAL_FRAME_CYC = 16'h0100;
  localparam logic [15:0] IDLE_FRAME_CYC   = 16'h0200;

  typedef enum logic [1:0] {
    ST_WAIT_CMD = 2'b00,
    ST_SSA_HI   = 2'b01,
    ST_SSA_LO   = 2'b10,
    ST_FMT      = 2'b11
  } cmd_state_t;

  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } pixel_t;
endpackage

//--- frame_tick.sv
// panel frame timer; period selects normal or eight colour frame rate
`timescale 1ns/1ps
module frame_tick (
  // clock and control
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [15:0] i_period,
  // frame start pulse
  output logic             o_tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  // count down; reload at each frame start so a new period lands on a frame edge
  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q - 16'h0001;
    if (cnt_q <= 16'h0001) begin
      cnt_d  = i_period;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= 16'h0001;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule

//--- scroll_idle_pixfmt_commands.sv
// command interpreter for scroll start, idle entry/exit and pixel format
// Functional notes
// (R1) scroll start: bit8 then bits7..0, reset zero
// (R2) start line shown after top fixed region
// (R3) scroll start command begins vertical scrolling
// (R4) new pointer applied at next frame start
// (R5) host pairs scroll start with area command
// (R6) idle exit returns to full colour
// (R7) idle exit ignored when idle off
// (R8) full colour depth outside idle mode
// (R9) normal frame rate outside idle mode
// (R10) idle entry enters idle, glitch free
// (R11) idle keeps only channel msbs
// (R12) idle uses eight colour frame rate
// (R13) idle entry ignored when idle on
// (R14) format bit: 0 six-six-six, 1 five-six-five
// (R15) commands accepted in every power state
// (R16) order bit 0 counts from top
// (R17) order bit 1 counts from bottom
// (R18) idle off after any reset
// (R19) lone first parameter leaves address unchanged
`timescale 1ns/1ps
module scroll_idle_pixfmt_commands #(
  parameter int LINES = 272
) (
  // clock, enable, reset
  input  wire logic                          i_clk,
  input  wire logic                          i_ce,
  input  wire logic                          i_rst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // pixel path
  input  wire scroll_idle_pkg::pixel_t       i_pixel,
  output scroll_idle_pkg::pixel_t            o_pixel,
  // display state
  output logic      [8:0]                    o_scroll_line,
  output logic                               o_scroll_on,
  output logic                               o_idle,
  output logic                               o_fmt_565,
  output logic                               o_bottom_up,
  output logic                               o_frame_start
);
  initial begin
    if (LINES < 1 || LINES > 512) $error("LINES must fit in nine bits");
  end

  scroll_idle_pkg::cmd_state_t st_q, st_d;
  logic [8:0]  ssa_pend_q, ssa_pend_d;     // staged pointer
  logic        ssa_hi_q, ssa_hi_d;         // first parameter held
  logic        ssa_new_q, ssa_new_d;
  logic [8:0]  ssa_q, ssa_d;               // applied pointer
  logic        scroll_pend_q, scroll_pend_d;
  logic        scroll_on_q, scroll_on_d;
  logic        idle_q, idle_d;             // requested idle
  logic        idle_view_q, idle_view_d;   // idle as shown on panel
  logic [7:0]  fmt_q, fmt_d;
  logic        fmt_view_q, fmt_view_d;
  logic        order_q, order_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q, err_d;
  scroll_idle_pkg::pixel_t pix_q, pix_d;
  logic        tick;
  logic        apb_wr;
  logic        apb_rd;
  logic [7:0]  wbyte;
  logic        soft_rst;

  // highest line the panel can show; out-of-range pointers clamp here
  localparam logic [8:0] SCROLL_LIMIT = 9'(LINES - 1);

  // known address check used for the pslverr answer to reads and writes
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == scroll_idle_pkg::ADDR_CMD)    || (a == scroll_idle_pkg::ADDR_PARAM) ||
              (a == scroll_idle_pkg::ADDR_CTRL)   || (a == scroll_idle_pkg::ADDR_STATUS) ||
              (a == scroll_idle_pkg::ADDR_SCROLL) || (a == scroll_idle_pkg::ADDR_FORMAT);
  endfunction

  // reduce a channel to its msb, repeated so the level is full or zero
  function automatic logic [5:0] msb_only(input logic [5:0] c);
    msb_only = {6{c[scroll_idle_pkg::CHAN_W-1]}};
  endfunction

  // access phase with one wait state: pready is registered, so the answer comes in the second access cycle
  assign apb_wr   = psel && penable && pwrite && !ready_q;
  assign apb_rd   = psel && penable && !pwrite && !ready_q;
  assign wbyte    = pwdata[7:0];
  assign soft_rst = apb_wr && (paddr == scroll_idle_pkg::ADDR_CTRL) && pwdata[scroll_idle_pkg::CTRL_SWRST_BIT];

  // frame timer; period follows the idle state shown on the panel
  frame_tick u_tick (
    .i_clk    (i_clk),
    .i_rst    (i_rst || (soft_rst && i_ce)),
    .i_ce     (i_ce),
    .i_period (idle_view_q ? scroll_idle_pkg::IDLE_FRAME_CYC : scroll_idle_pkg::NORMAL_FRAME_CYC), // R9 R12
    .o_tick   (tick)
  );

  // command and parameter interpretation; accepted in every power state
  always_comb begin
    st_d          = st_q;
    ssa_pend_d    = ssa_pend_q;
    ssa_hi_d      = ssa_hi_q;
    ssa_new_d     = ssa_new_q;
    scroll_pend_d = scroll_pend_q;
    idle_d        = idle_q;
    fmt_d         = fmt_q;
    order_d       = order_q;
    if (apb_wr && paddr == scroll_idle_pkg::ADDR_CMD) begin // R15
      st_d     = scroll_idle_pkg::ST_WAIT_CMD;
      ssa_hi_d = 1'b0; // R19
      unique case (wbyte)
        scroll_idle_pkg::CMD_SCROLL_START: st_d = scroll_idle_pkg::ST_SSA_HI;
        scroll_idle_pkg::CMD_IDLE_EXIT: begin
          if (idle_q) idle_d = 1'b0; // R6 R7
        end
        scroll_idle_pkg::CMD_IDLE_ENTRY: begin
          if (!idle_q) idle_d = 1'b1; // R10 R13
        end
        scroll_idle_pkg::CMD_PIXEL_FORMAT: st_d = scroll_idle_pkg::ST_FMT;
        default: st_d = scroll_idle_pkg::ST_WAIT_CMD;
      endcase
    end else if (apb_wr && paddr == scroll_idle_pkg::ADDR_PARAM) begin
      unique case (st_q)
        scroll_idle_pkg::ST_SSA_HI: begin
          ssa_pend_d[8] = wbyte[scroll_idle_pkg::ADDR_HI_BIT]; // R1
          ssa_hi_d      = 1'b1;
          st_d          = scroll_idle_pkg::ST_SSA_LO;
        end
        scroll_idle_pkg::ST_SSA_LO: begin
          ssa_pend_d[7:0] = wbyte; // R1
          ssa_new_d       = 1'b1;
          scroll_pend_d   = 1'b1; // R3
          ssa_hi_d        = 1'b0;
          st_d            = scroll_idle_pkg::ST_WAIT_CMD;
        end
        scroll_idle_pkg::ST_FMT: begin
          fmt_d = wbyte; // R14
          st_d  = scroll_idle_pkg::ST_WAIT_CMD;
        end
        scroll_idle_pkg::ST_WAIT_CMD: st_d = scroll_idle_pkg::ST_WAIT_CMD;
      endcase
    end else if (apb_wr && paddr == scroll_idle_pkg::ADDR_CTRL) begin
      order_d = pwdata[scroll_idle_pkg::CTRL_ORDER_BIT]; // R16 R17
    end
    if (tick) begin
      ssa_new_d     = 1'b0;
      scroll_pend_d = 1'b0;
    end
    // a parameter landing on the tick stays pending for the next frame
    if (apb_wr && paddr == scroll_idle_pkg::ADDR_PARAM && st_q == scroll_idle_pkg::ST_SSA_LO) begin
      ssa_new_d     = 1'b1;
      scroll_pend_d = 1'b1;
    end
  end

  // scroll pointer, scroll enable, idle and format views change only at frame start, so no tearing or glitch
  always_comb begin
    ssa_d       = ssa_q;
    scroll_on_d = scroll_on_q;
    idle_view_d = idle_view_q;
    fmt_view_d  = fmt_view_q;
    if (tick) begin
      if (ssa_new_q) ssa_d = (ssa_pend_q < 9'(LINES)) ? ssa_pend_q : SCROLL_LIMIT; // R2 R4
      if (scroll_pend_q) scroll_on_d = 1'b1; // R3 R4
      idle_view_d = idle_q; // R10
      fmt_view_d  = fmt_q[scroll_idle_pkg::FMT_BIT]; // R4
    end
  end

  // pixel reduction: msb only in idle, red and blue lsb cleared in 5-6-5, full depth otherwise
  always_comb begin
    pix_d = i_pixel; // R8
    if (fmt_view_q) pix_d.b = {i_pixel.b[5:1], 1'b0}; // five bit blue in 5-6-5
    if (fmt_view_q) pix_d.r = {i_pixel.r[5:1], 1'b0};
    if (idle_view_q) begin
      pix_d.r = msb_only(i_pixel.r); // R11
      pix_d.g = msb_only(i_pixel.g); // R11
      pix_d.b = msb_only(i_pixel.b); // R11
    end
  end

  // apb read mux and answer; unmapped addresses give pslverr
  always_comb begin
    rdata_d = 32'h0000_0000;
    ready_d = psel && penable && !ready_q;
    err_d   = psel && penable && !ready_q && !addr_ok(paddr);
    if (apb_rd) begin
      unique case (paddr)
        scroll_idle_pkg::ADDR_CTRL:   rdata_d = {31'h0000_0000, order_q};
        scroll_idle_pkg::ADDR_STATUS: rdata_d = {26'h000_0000, st_q, ssa_hi_q, scroll_on_q, idle_view_q, idle_q};
        scroll_idle_pkg::ADDR_SCROLL: rdata_d = {23'h00_0000, ssa_q};
        scroll_idle_pkg::ADDR_FORMAT: rdata_d = {24'h00_0000, fmt_q};
        default:                      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // register all state; software reset restores the reset values, except pready which is set to answer the write
  always_ff @(posedge i_clk) begin
    if (i_rst || (soft_rst && i_ce)) begin
      st_q          <= scroll_idle_pkg::ST_WAIT_CMD;
      ssa_pend_q    <= scroll_idle_pkg::SCROLL_RESET; // R1
      ssa_hi_q      <= 1'b0;
      ssa_new_q     <= 1'b0;
      ssa_q         <= scroll_idle_pkg::SCROLL_RESET;
      scroll_pend_q <= 1'b0;
      scroll_on_q   <= 1'b0;
      idle_q        <= 1'b0; // R18
      idle_view_q   <= 1'b0; // R18
      fmt_q         <= scroll_idle_pkg::FORMAT_RESET; // R14
      fmt_view_q    <= scroll_idle_pkg::FORMAT_RESET[scroll_idle_pkg::FMT_BIT];
      order_q       <= 1'b0;
      pix_q         <= '0;
      rdata_q       <= 32'h0000_0000;
      ready_q       <= i_rst ? 1'b0 : 1'b1;
      err_q         <= 1'b0;
    end else if (i_ce) begin
      st_q          <= st_d;
      ssa_pend_q    <= ssa_pend_d;
      ssa_hi_q      <= ssa_hi_d;
      ssa_new_q     <= ssa_new_d;
      ssa_q         <= ssa_d;
      scroll_pend_q <= scroll_pend_d;
      scroll_on_q   <= scroll_on_d;
      idle_q        <= idle_d;
      idle_view_q   <= idle_view_d;
      fmt_q         <= fmt_d;
      fmt_view_q    <= fmt_view_d;
      order_q       <= order_d;
      pix_q         <= pix_d;
      rdata_q       <= rdata_d;
      ready_q       <= ready_d;
      err_q         <= err_d;
    end
  end

  // outputs straight from flip-flops (tick is a flop in the timer)
  assign prdata        = rdata_q;
  assign pready        = ready_q;
  assign pslverr       = err_q;
  assign o_pixel       = pix_q;
  assign o_scroll_line = ssa_q;
  assign o_scroll_on   = scroll_on_q;
  assign o_idle        = idle_view_q;
  assign o_fmt_565     = fmt_view_q;
  assign o_bottom_up   = order_q; // R17
  assign o_frame_start = tick;
endmodule

//--- scroll_idle_properties.sv
// assertion checker for the scroll, idle and pixel format command block
`timescale 1ns/1ps
module scroll_idle_checker (
  // clock and reset
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  // apb handshake
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // pixel path and display state
  input wire scroll_idle_pkg::pixel_t i_pixel,
  input wire scroll_idle_pkg::pixel_t o_pixel,
  input wire logic [8:0]              o_scroll_line,
  input wire logic                    o_scroll_on,
  input wire logic                    o_idle,
  input wire logic                    o_fmt_565,
  input wire logic                    o_frame_start
);
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic       seen_q;
  logic       seen_d;
  logic       per_idle_q;                 // idle level that set the running frame's period
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // cycles since last frame start; seen masks the partial first frame after reset
  always_comb begin
    cnt_d  = o_frame_start ? 10'h001 : cnt_q + 10'h001;
    seen_d = seen_q | o_frame_start;
  end
  always_ff @(posedge i_clk) begin
    cnt_q  <= i_rst ? 10'h000 : cnt_d;
    seen_q <= i_rst ? 1'h0 : seen_d;
  end
  // the period is reloaded at a frame start from the idle level shown before that edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      per_idle_q <= 1'h0;
    end else if (o_frame_start) begin
      per_idle_q <= o_idle;
    end
  end
  sequence acc_s; psel && penable && !pready; endsequence
  sequence ans_s; pready ##1 !pready; endsequence
  rst_values_a: assert property (disable iff (1'h0) i_rst |=> !o_idle && o_fmt_565 && o_scroll_line == 9'h000
    && !o_scroll_on) else $error("state not at reset values");
  access_answer_a: assert property (acc_s |=> ans_s) else $error("access not answered next cycle");
  error_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  idle_at_frame_a: assert property ($rose(o_idle) |-> o_frame_start || $past(o_frame_start))
    else $error("idle applied off a frame start");
  scroll_at_frame_a: assert property ($changed(o_scroll_line) && !$past(i_rst) |-> o_frame_start
    || $past(o_frame_start)) else $error("scroll line applied off a frame start");
  frame_period_a: assert property (o_frame_start && seen_q |-> cnt_q == (per_idle_q ? 10'h200 : 10'h100))
    else $error("frame period wrong");
  idle_pixel_a: assert property (o_idle && $past(o_idle) && !$past(i_rst) |-> o_pixel ==
    {{6{$past(i_pixel.r[5])}}, {6{$past(i_pixel.g[5])}}, {6{$past(i_pixel.b[5])}}}) else $error("idle pixel wrong");
  full_pixel_a: assert property (!o_idle && !$past(o_idle) && !o_fmt_565 && !$past(o_fmt_565) && !$past(i_rst)
    |-> o_pixel == $past(i_pixel)) else $error("full colour pixel wrong");
  fmt565_pixel_a: assert property (!o_idle && !$past(o_idle) && o_fmt_565 && $past(o_fmt_565) && !$past(i_rst)
    |-> o_pixel == ($past(i_pixel) & 18'h3EFFE)) else $error("five six five pixel wrong");
endmodule
bind scroll_idle_pixfmt_commands scroll_idle_checker i_chk (.i_clk, .i_rst, .psel, .penable, .pready, .pslverr,
  .i_pixel, .o_pixel, .o_scroll_line, .o_scroll_on, .o_idle, .o_fmt_565, .o_frame_start);

//--- host_apb_model.sv
// host processor model issuing commands and parameters over apb
`timescale 1ns/1ps
module host_apb_model (
  // clock
  input  wire logic        i_clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // a wait ran out of its bound
  output logic             o_hang
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, o_hang} = 43'h0;
  end
  // setup, then access held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge i_clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 64) o_hang <= 1'h1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'h1, a, {24'h0, d}, q, e);
  endtask
  // area definition goes first so regions and mode are both fixed when scrolling starts
  task automatic scroll(input logic [8:0] line);
    wr(scroll_idle_pkg::ADDR_CMD, scroll_idle_pkg::CMD_SCROLL_AREA);
    repeat (2) wr(scroll_idle_pkg::ADDR_PARAM, 8'h00);
    wr(scroll_idle_pkg::ADDR_PARAM, 8'h01);
    wr(scroll_idle_pkg::ADDR_PARAM, 8'h10);
    wr(scroll_idle_pkg::ADDR_CMD, scroll_idle_pkg::CMD_SCROLL_START);
    wr(scroll_idle_pkg::ADDR_PARAM, {7'h0, line[8]});
    wr(scroll_idle_pkg::ADDR_PARAM, line[7:0]);
  endtask
endmodule

//--- tb.sv
// self-checking bench for the scroll, idle and pixel format command block
`timescale 1ns/1ps
module tb;
  logic                    i_clk, i_rst, i_ce, psel, penable, pwrite, pready, pslverr, hang, e;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, q;
  scroll_idle_pkg::pixel_t i_pixel, o_pixel;
  logic [8:0]              o_scroll_line;
  logic                    o_scroll_on, o_idle, o_fmt_565, o_bottom_up, o_frame_start;
  int                      error_cnt, total_checks;
  scroll_idle_pixfmt_commands i_dut (.i_clk, .i_ce, .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_pixel, .o_pixel, .o_scroll_line, .o_scroll_on, .o_idle, .o_fmt_565, .o_bottom_up,
    .o_frame_start);
  host_apb_model i_host (.i_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .o_hang(hang));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'h0, a, 32'h0, q, e);
  endtask
  task automatic cmd(input logic [7:0] c);
    i_host.wr(scroll_idle_pkg::ADDR_CMD, c);
  endtask
  // new state only shows from the next frame start, so each check after a command waits for one
  task automatic frame;
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_frame_start !== 1'h1 && n < 1200);
    if (n >= 1200) begin
      error_cnt++;
      results();
    end
    repeat (2) @(negedge i_clk);
  endtask
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  // a bounded wait that ran out ends the run
  always @(posedge hang) begin
    error_cnt++;
    results();
  end
  initial begin
    {i_rst, i_ce, i_pixel} = {2'h3, 18'h267F1};
    repeat (16) @(posedge i_clk);
    i_rst <= 1'h0;
    rd(scroll_idle_pkg::ADDR_SCROLL); chk(q, 32'h0);
    rd(scroll_idle_pkg::ADDR_FORMAT); chk(q, 32'h01);
    rd(scroll_idle_pkg::ADDR_STATUS); chk(32'(q[1:0]), 32'h0);
    chk(32'(o_pixel), 32'h267F0);
    rd(8'h20); chk({q[30:0], e}, 32'h1);
    $display("test reset and unmapped done");
    i_host.scroll(9'h105);
    frame();
    chk({o_scroll_on, 22'h0, o_scroll_line}, 32'h80000105);
    cmd(scroll_idle_pkg::CMD_SCROLL_START);
    i_host.wr(scroll_idle_pkg::ADDR_PARAM, 8'h00);
    cmd(scroll_idle_pkg::CMD_IDLE_ENTRY);
    frame();
    chk({o_idle, 22'h0, o_scroll_line}, 32'h80000105);
    chk(32'(o_pixel), 32'h3F03F);
    cmd(scroll_idle_pkg::CMD_IDLE_ENTRY);
    cmd(scroll_idle_pkg::CMD_PIXEL_FORMAT);
    i_host.wr(scroll_idle_pkg::ADDR_PARAM, 8'h00);
    frame();
    chk(32'(o_idle), 32'h1);
    rd(scroll_idle_pkg::ADDR_FORMAT); chk(q, 32'h0);
    cmd(scroll_idle_pkg::CMD_IDLE_EXIT);
    frame();
    chk({o_idle, o_fmt_565, 12'h0, o_pixel}, 32'h267F1);
    cmd(scroll_idle_pkg::CMD_IDLE_EXIT);
    frame();
    chk(32'(o_idle), 32'h0);
    $display("test scroll idle format done");
    for (int v = 1; v >= 0; v--) begin
      i_host.wr(scroll_idle_pkg::ADDR_CTRL, 8'(v));
      frame();
      chk(32'(o_bottom_up), 32'(v));
    end
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    @(negedge i_clk);
    chk({o_idle, o_fmt_565, o_scroll_on, 20'h0, o_scroll_line}, 32'h40000000);
    $display("test order bit and reset done");
    results();
  end
endmodule
